/* File: usst_pkg.sv */
package usst_pkg;
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;
  localparam logic [1:0] WM_TWO_OVH = 2'h3;
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] CS_EXT_POS = 2'h2;
  localparam logic [1:0] CS_EXT_NEG = 2'h3;
  localparam int SYS_CLK_MHZ = 250;
  localparam int SDA_DLY_MIN_NS = 50;
  localparam int SDA_DLY_MAX_NS = 300;
  localparam int SDA_DLY_CYC = (SDA_DLY_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SDA_DLY_MAX_CYC = SDA_DLY_MAX_NS * SYS_CLK_MHZ / 1000;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int MSB_BIT = 7;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    SH_IDLE = 3'h1,
    SH_ARMED = 3'h2,
    SH_HOLD = 3'h4
  } usst_hold_type;

  typedef struct packed {
    logic [1:0] wire_mode;
    logic [1:0] clk_sel;
  } usst_ctrl_type;

  typedef struct packed {
    logic data_wr;
    logic [DATA_W-1:0] data_wdat;
    logic cnt_wr;
    logic [CNT_W-1:0] cnt_wdat;
    logic start_clr;
    logic ovf_clr;
    logic soft_strobe;
  } usst_cpu_type;

  typedef struct packed {
    logic sda_dir;
    logic sda_port;
    logic scl_dir;
    logic scl_port;
    logic do_dir;
  } usst_port_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CNT_W-1:0] cnt;
    logic start_flag;
    logic ovf_flag;
  } usst_stat_type;
endpackage

/* File: usst_unit.sv */
module usst_unit #(
  parameter int DLY_CYC = usst_pkg::SDA_DLY_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire usst_pkg::usst_ctrl_type ctrl_i,
  input wire usst_pkg::usst_cpu_type cpu_i,
  input wire usst_pkg::usst_port_type port_i,
  input wire logic timer_tick_i,
  input wire logic sda_i,
  input wire logic scl_i,
  output usst_pkg::usst_stat_type stat_o,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic scl_o,
  output logic scl_oe_n_o,
  output logic do_o,
  output logic do_oe_n_o
);
  import usst_pkg::*;

  // Link domain: one toggle per serial clock edge
  logic rise_tgl_q;
  logic fall_tgl_q;

  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rise_tgl_q <= 1'b0;
    end else begin
      rise_tgl_q <= ~rise_tgl_q;
    end
  end

  always_ff @(negedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fall_tgl_q <= 1'b0;
    end else begin
      fall_tgl_q <= ~fall_tgl_q;
    end
  end

  // System domain synchronisers
  logic [2:0] rise_sync_q;
  logic [2:0] fall_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;
  logic [DLY_CYC-1:0] sda_dly_q;
  logic sda_dly_prev_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rise_sync_q <= 3'h0;
      fall_sync_q <= 3'h0;
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
    end else begin
      rise_sync_q <= {rise_sync_q[1:0], rise_tgl_q};
      fall_sync_q <= {fall_sync_q[1:0], fall_tgl_q};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_sync_q <= {scl_sync_q[0], scl_i};
    end
  end

  // Delay must exceed the clock sync path so a clock fall is seen first
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_dly_q <= '1;
      sda_dly_prev_q <= 1'b1;
    end else begin
      sda_dly_q <= {sda_dly_q[DLY_CYC-2:0], sda_sync_q[1]};
      sda_dly_prev_q <= sda_dly_q[DLY_CYC-1];
    end
  end

  wire logic sda_s = sda_sync_q[1];
  wire logic scl_s = scl_sync_q[1];
  wire logic sda_dly = sda_dly_q[DLY_CYC-1];
  // Edge rate above a quarter of clk_i would merge toggles
  wire logic rise_evt = rise_sync_q[2] ^ rise_sync_q[1];
  wire logic fall_evt = fall_sync_q[2] ^ fall_sync_q[1];

  // Mode and clock selection
  wire logic two_wire = ctrl_i.wire_mode[1];
  wire logic three_wire = (ctrl_i.wire_mode == WM_THREE);
  wire logic ovh_mode = (ctrl_i.wire_mode == WM_TWO_OVH);
  wire logic ext_clk = ctrl_i.clk_sel[1];
  wire logic edge_inv = ctrl_i.clk_sel[0];
  wire logic soft_evt = (ctrl_i.clk_sel == CS_SOFT) & cpu_i.soft_strobe;
  // Timer compare clocks the counter, extending the timer by 4 bits
  wire logic tmr_evt = (ctrl_i.clk_sel == CS_TIMER) & timer_tick_i;
  wire logic int_evt = soft_evt | tmr_evt;
  wire logic samp_evt = ext_clk & (edge_inv ? fall_evt : rise_evt);
  wire logic shft_ext = ext_clk & (edge_inv ? rise_evt : fall_evt);
  wire logic cnt_evt = ext_clk ?
      (rise_evt | fall_evt | cpu_i.soft_strobe) : int_evt;
  wire logic shift_evt = ext_clk ? shft_ext : int_evt;

  // Sample edge captures, opposite edge shifts; MSB then moves away
  // from the sampling edge like a transparent output latch.
  logic samp_q;
  wire logic shift_bit = ext_clk ? samp_q : sda_s;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      samp_q <= 1'b0;
    end else if (samp_evt) begin
      samp_q <= sda_s;
    end
  end

  // Shift register; a CPU write wins over a same-cycle shift
  logic [DATA_W-1:0] data_q;
  wire logic [DATA_W-1:0] data_shift = {data_q[DATA_W-2:0], shift_bit};
  wire logic [DATA_W-1:0] data_d = cpu_i.data_wr ? cpu_i.data_wdat :
      shift_evt ? data_shift : data_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= DATA_RST;
    end else begin
      data_q <= data_d;
    end
  end

  // Counter and overflow flag
  logic [CNT_W-1:0] cnt_q;
  logic ovf_q;
  wire logic cnt_inc = cnt_evt & ~cpu_i.cnt_wr;
  wire logic ovf_set = cnt_inc & (cnt_q == CNT_MAX);
  wire logic [CNT_W-1:0] cnt_d = cpu_i.cnt_wr ? cpu_i.cnt_wdat :
      cnt_inc ? cnt_q + CNT_ONE : cnt_q;
  // Set wins over a same-cycle clear
  wire logic ovf_d = ovf_set | (ovf_q & ~cpu_i.ovf_clr);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= CNT_RST;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  // Start detector; sampled, so it cannot run with clk_i stopped
  logic start_q;
  wire logic start_det = two_wire & scl_s & sda_dly_prev_q &
      ~sda_dly;
  // Outside two-wire mode the flag follows counter increments
  wire logic start_set = two_wire ? start_det : cnt_inc;
  wire logic start_d = start_set | (start_q & ~cpu_i.start_clr);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

  // Start hold: arm on start, hold after master pulls clock low
  usst_hold_type sh_q;
  usst_hold_type sh_d;

  always_comb begin
    sh_d = sh_q;
    case (sh_q)
      SH_IDLE: begin
        if (start_det) begin
          sh_d = SH_ARMED;
        end
      end
      SH_ARMED: begin
        if (!start_q) begin
          sh_d = SH_IDLE;
        end else if (!scl_s) begin
          sh_d = SH_HOLD;
        end
      end
      SH_HOLD: begin
        if (!start_q) begin
          sh_d = SH_IDLE;
        end
      end
      default: begin
        sh_d = SH_IDLE;
      end
    endcase
    if (!two_wire) begin
      sh_d = SH_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sh_q <= SH_IDLE;
    end else begin
      sh_q <= sh_d;
    end
  end

  // Pin drivers; SDA and SCL only pull down, the slave never makes clock edges
  wire logic start_hold = (sh_q == SH_HOLD);
  wire logic ovf_hold = ovh_mode & ovf_q;
  wire logic port_scl_low = port_i.scl_dir & ~port_i.scl_port;
  wire logic scl_low = two_wire &
      (port_scl_low | start_hold | ovf_hold);
  // No acknowledge unless software sets direction and a zero MSB or a zero port bit
  wire logic sda_low = two_wire & port_i.sda_dir &
      (~data_q[MSB_BIT] | ~port_i.sda_port);
  wire logic do_en = three_wire & port_i.do_dir;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
      do_o <= 1'b0;
      do_oe_n_o <= 1'b1;
    end else begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe_n_o <= ~sda_low;
      scl_oe_n_o <= ~scl_low;
      do_o <= data_q[MSB_BIT];
      do_oe_n_o <= ~do_en;
    end
  end

  assign stat_o = '{data: data_q, cnt: cnt_q, start_flag: start_q,
                    ovf_flag: ovf_q};

  ovf_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cnt_evt && !cpu_i.cnt_wr && cnt_q == CNT_MAX |=> ovf_q && cnt_q == CNT_RST)
    else $error("overflow not flagged on wrap");

  ovf_sticky_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovf_q && !cpu_i.ovf_clr |=> ovf_q)
    else $error("overflow flag lost without clear");

  cnt_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ext_clk && (rise_evt || fall_evt) && !cpu_i.cnt_wr
    |=> cnt_q == 4'($past(cnt_q) + CNT_ONE))
    else $error("counter missed an edge");

  start_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    two_wire && scl_s && $fell(sda_dly) |=> start_q)
    else $error("start condition not flagged");

  start_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !two_wire |=> sh_q == SH_IDLE ##1 scl_oe_n_o || !two_wire)
    else $error("start hold outside two-wire mode");

  scl_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sh_q == SH_ARMED && !scl_s && start_q && two_wire
    |=> sh_q == SH_HOLD ##1 !scl_oe_n_o)
    else $error("clock not held after start");

  hold_rel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sh_q == SH_HOLD && !start_q |=> sh_q == SH_IDLE)
    else $error("start hold not released");

  sda_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    two_wire && port_i.sda_dir && !data_q[MSB_BIT] |=> !sda_oe_n_o)
    else $error("data line not driven low");

  sda_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !port_i.sda_dir |=> sda_oe_n_o)
    else $error("data line driven without direction");

  shift_in_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    shift_evt && !cpu_i.data_wr
    |=> data_q == {$past(data_q[DATA_W-2:0]), $past(shift_bit)})
    else $error("shift register did not shift");

  do_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    three_wire && port_i.do_dir |=> !do_oe_n_o && do_o == $past(data_q[7]))
    else $error("three-wire output wrong");

  // Register, flag and pin checks
  scl_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sh_q != SH_HOLD && !ovf_hold && !port_scl_low |=> scl_oe_n_o)
    else $error("clock line held without cause");

  ovf_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovh_mode && ovf_q |=> !scl_oe_n_o)
    else $error("clock not held on overflow");

  wire_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !two_wire |=> scl_oe_n_o && sda_oe_n_o)
    else $error("bus driven outside two-wire mode");

  data_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cpu_i.data_wr |=> stat_o.data == $past(cpu_i.data_wdat))
    else $error("shift register write lost");

  cnt_preset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cpu_i.cnt_wr |=> cnt_q == $past(cpu_i.cnt_wdat))
    else $error("counter preset lost");

  ovf_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovf_q && cpu_i.ovf_clr && !ovf_set |=> !ovf_q)
    else $error("overflow flag not cleared");

  ovf_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ovf_q && !ovf_set |=> !ovf_q)
    else $error("overflow flag set without wrap");

  start_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    start_q && cpu_i.start_clr && !start_set |=> !start_q)
    else $error("start flag not cleared");

  start_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    start_q && !cpu_i.start_clr |=> start_q)
    else $error("start flag lost without clear");

  cnt_still_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !cnt_evt && !cpu_i.cnt_wr |=> $stable(cnt_q))
    else $error("counter moved without a clock");

  sample_bit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    samp_evt |=> samp_q == $past(sda_s))
    else $error("data line not sampled");

  do_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !three_wire |=> do_oe_n_o)
    else $error("data output driven outside three-wire");

  sda_port_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    two_wire && port_i.sda_dir && !port_i.sda_port |=> !sda_oe_n_o)
    else $error("port bit did not pull data low");

  sda_free_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    port_i.sda_port && data_q[MSB_BIT] |=> sda_oe_n_o)
    else $error("data line pulled with MSB one");

  tmr_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_i.clk_sel == CS_TIMER && timer_tick_i && !cpu_i.cnt_wr
    |=> cnt_q == 4'($past(cnt_q) + CNT_ONE))
    else $error("timer tick not counted");

  edge_irq_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ext_clk && cnt_q == CNT_MAX && (rise_evt || fall_evt) && !cpu_i.cnt_wr
    |=> ovf_q)
    else $error("pin edge did not overflow");

  pull_only_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> !scl_o && !sda_o)
    else $error("bus line driven high");

  soft_shift_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_i.clk_sel == CS_SOFT && cpu_i.soft_strobe && !cpu_i.data_wr
    |=> data_q == {$past(data_q[DATA_W-2:0]), $past(sda_s)})
    else $error("soft strobe did not shift");
endmodule

/* File: usst_bus_master.sv */
module usst_bus_master (
  input wire logic scl_i,
  input wire logic din_i,
  output logic scl_low_o,
  output logic sda_low_o,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low_o = 1'h0;
    sda_low_o = 1'h0;
    rx_o = 8'h00;
  end
  // Waits out any slave hold before the high half
  task automatic rel_scl();
    scl_low_o = 1'h0;
    repeat (2000) if (!scl_i) #4;
    #16;
  endtask
  // Data line falls while the clock is high
  task automatic start();
    #1.3 sda_low_o = 1'h1;
    #32 scl_low_o = 1'h1;
    #32;
  endtask
  task automatic sda_blip();
    sda_low_o = 1'h1;
    #40 sda_low_o = 1'h0;
  endtask
  // MSB first, 64 ns per bit keeps well under fck/4
  task automatic xfer(input logic [7:0] tx, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      // Early data change so the delayed copy lands before the clock rise
      #8 sda_low_o = ~tx[i];
      #24 rel_scl();
      rx_o = {rx_o[6:0], din_i};
      #16 scl_low_o = 1'h1;
    end
  endtask
  task automatic stop();
    sda_low_o = 1'h1;
    #16 rel_scl();
    #16 sda_low_o = 1'h0;
  endtask
endmodule

/* File: test_universal_serial_shift_two_wire.sv */
module test_universal_serial_shift_two_wire;
  timeunit 1ns;
  timeprecision 100ps;
  import usst_pkg::*;
  typedef struct {
    string nm;
    logic [24:0] m;
    logic [24:0] v;
  } usst_note_type;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  usst_ctrl_type ctrl;
  usst_cpu_type cpu;
  usst_port_type port;
  usst_stat_type stat;
  logic tick, sda_oe_n, scl_oe_n, do_o, do_oe_n, m_scl_low, m_sda_low;
  logic [7:0] m_rx, b, r;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  usst_note_type notes[$];
  usst_note_type n;
  event look;
  // Open-drain lines with pull-ups
  wire scl_bus = ~m_scl_low & scl_oe_n;
  wire sda_bus = ~m_sda_low & sda_oe_n;
  wire do_line = do_oe_n ? ~do_o : do_o;
  wire din = (ctrl.wire_mode == WM_THREE) ? do_line : sda_bus;
  wire [24:0] snap = {stat, sda_oe_n, scl_oe_n, do_oe_n, m_rx};
  always #2 clk_i = ~clk_i;
  usst_unit #(.DLY_CYC(4)) usst_unit_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .link_clk_i(scl_bus), .ctrl_i(ctrl),
    .cpu_i(cpu), .port_i(port), .timer_tick_i(tick), .sda_i(sda_bus),
    .scl_i(scl_bus), .stat_o(stat), .sda_o(), .sda_oe_n_o(sda_oe_n),
    .scl_o(), .scl_oe_n_o(scl_oe_n), .do_o(do_o), .do_oe_n_o(do_oe_n));
  usst_bus_master usst_bus_master_inst (.scl_i(scl_bus), .din_i(din),
    .scl_low_o(m_scl_low), .sda_low_o(m_sda_low), .rx_o(m_rx));
  function automatic logic [24:0] pk(logic [7:0] d, logic [3:0] c,
      logic [4:0] f, logic [7:0] x);
    return {d, c, f, x};
  endfunction
  task automatic check(string nm, logic [24:0] seen, logic [24:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic note(string nm, logic [24:0] m, logic [24:0] v);
    notes.push_back('{nm, m, v});
    -> look;
    repeat (2) @(negedge clk_i);
  endtask
  always @(look) begin
    @(negedge clk_i);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(n.nm, snap & n.m, n.v & n.m);
    end
  end
  task automatic cpu_op(usst_cpu_type c);
    @(negedge clk_i) cpu = c;
    @(negedge clk_i) cpu = '0;
  endtask
  task automatic wait_ovf();
    repeat (100) if (!stat.ovf_flag) @(negedge clk_i);
    repeat (4) @(negedge clk_i);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hB3EBC79F));
    ctrl = '{WM_TWO_OVH, CS_EXT_POS};
    cpu = '0;
    port = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0};
    tick = 1'h0;
    b = 8'($urandom);
    r = 8'($urandom);
    repeat (16) @(negedge clk_i);
    sys_rst_i = 1'h0;
    repeat (3) @(negedge clk_i);
    note("reset", 25'h1FFFF00, pk(8'h00, 4'h0, 5'h07, 8'h00));
    cpu_op('{1'h1, 8'hFF, 1'h1, 4'h0, 1'h0, 1'h0, 1'h0});
    usst_bus_master_inst.start();
    repeat (50) if (!stat.start_flag) @(negedge clk_i);
    repeat (4) @(negedge clk_i);
    note("start", 25'h1FE00, pk(8'h00, 4'h1, 5'h14, 8'h00));
    fork
      usst_bus_master_inst.xfer(b, 8);
      begin
        repeat (20) @(negedge clk_i);
        note("stretch", 25'h200, 25'h0);
        cpu_op('{1'h0, 8'h00, 1'h1, 4'h0, 1'h1, 1'h0, 1'h0});
      end
    join
    wait_ovf();
    note("byte", 25'h1FFFE00, pk(b, 4'h0, 5'h0C, 8'h00));
    // Slave answers the address with a low acknowledge bit
    port.sda_dir = 1'h1;
    cpu_op('{1'h1, 8'h00, 1'h1, 4'hE, 1'h0, 1'h1, 1'h0});
    usst_bus_master_inst.xfer(8'hFF, 1);
    wait_ovf();
    note("ack", 25'h1EA01, pk(8'h00, 4'h0, 5'h08, 8'h00));
    port.sda_dir = 1'h0;
    cpu_op('{1'h0, 8'h00, 1'h0, 4'h0, 1'h1, 1'h1, 1'h0});
    usst_bus_master_inst.stop();
    @(negedge clk_i);
    ctrl.wire_mode = WM_THREE;
    port.do_dir = 1'h1;
    cpu_op('{1'h1, ~b, 1'h1, 4'h0, 1'h1, 1'h1, 1'h0});
    usst_bus_master_inst.sda_blip();
    repeat (8) @(negedge clk_i);
    note("blip", 25'h1100, 25'h0);
    usst_bus_master_inst.start();
    // Reload after the falling clock of the start, which shifts once
    cpu_op('{1'h1, ~b, 1'h1, 4'h0, 1'h0, 1'h0, 1'h0});
    usst_bus_master_inst.xfer(r, 8);
    wait_ovf();
    note("three", 25'h1FE08FF, pk(r, 4'h0, 5'h08, ~b));
    cpu_op('{1'h0, 8'h00, 1'h1, 4'hF, 1'h0, 1'h1, 1'h0});
    usst_bus_master_inst.rel_scl();
    wait_ovf();
    note("edge", 25'h1E800, pk(8'h00, 4'h0, 5'h08, 8'h00));
    ctrl.clk_sel = CS_TIMER;
    cpu_op('{1'h0, 8'h00, 1'h1, 4'h0, 1'h0, 1'h1, 1'h0});
    b = 8'(1 + $urandom % 14);
    repeat (b) begin
      @(negedge clk_i) tick = 1'h1;
      @(negedge clk_i) tick = 1'h0;
    end
    note("timer", 25'h1E800, pk(8'h00, b[3:0], 5'h00, 8'h00));
    end_of_test();
  end
endmodule
